// ===== afr_defines.svh
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH

// ----------------------------------------------------------------
// function register field positions
// ----------------------------------------------------------------
`define AFR_BIT_LATCHED   0
`define AFR_BIT_CALIB     1
`define AFR_BIT_HOLD      2
`define AFR_BIT_PDOWN     3
`define AFR_BIT_RSVD      4
`define AFR_BIT_PFAIL     5
`define AFR_BIT_CALERR    6
`define AFR_BIT_BUSY      7

// ----------------------------------------------------------------
// reset values and reserved read data
// ----------------------------------------------------------------
`define AFR_RESET_LATCHED 1'b0
`define AFR_RESET_HOLD    1'b0
`define AFR_RESET_PDOWN   1'b1
`define AFR_RESERVED_DATA 8'h00

// ----------------------------------------------------------------
// timing, in converter clock cycles except the MCLK period in ns (converter clock = MCLK)
// ----------------------------------------------------------------
`define AFR_MCLK_PERIOD_NS    25
`define AFR_CONV_CYCLES       17
`define AFR_CAL_CYCLES        4608
`define AFR_SETTLE_CYCLES     37393
`define AFR_PD_CAL_TOTAL      185
// hold-edge to conversion start, longest, in tenths of a clock cycle
`define AFR_HOLD_START_MAX_X10 15
`define AFR_HOLD_START_CYC    ((`AFR_HOLD_START_MAX_X10) / 10)

`endif

// ===== afr_pkg.sv
package afr_pkg;
`include "afr_defines.svh"

   typedef enum logic [1:0]
   {
      AFR_IDLE,
      AFR_SETTLE,
      AFR_CAL,
      AFR_CONV
   } afr_state_t;

   typedef struct packed
   {
      afr_state_t st;
      logic [15:0] cnt;
      logic       latched;
      logic       calib;
      logic       hold;
      logic       pdown;
      logic       pfail;
      logic       calerr;
      logic       wr_d;
      logic [7:0] wdata;
      logic [2:0] wsel;
      logic [1:0] wchan;
      logic       cal_d;
      logic       low_d;
      logic       short_cal;
      logic [1:0] chan;
      logic [7:0] dout;
      logic       oe_n;
      logic       busy_n;
      logic       conv_start;
      logic       cal_start;
      logic       out_latch_en;
      logic       clk_run;
   } afr_regs_t;

endpackage

// ===== afr_rst_sync.sv
`timescale 1ns/1ps
module afr_rst_sync
(
   input  wire logic clk,        // clock
   input  wire logic arst_n,     // asynchronous reset in
   output logic      rst_n       // released reset
);
   logic meta;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta  <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         meta  <= 1'b1;
         rst_n <= meta;
      end
   end
endmodule // afr_rst_sync

// ===== afr_func_reg.sv
`timescale 1ns/1ps
`include "afr_defines.svh"
// Overview of operation
// - function/high-byte select read drives register
// - D0 reports pass-through or latched output
// - D1 high while calibration runs
// - D2 selects calibrate or hold input
// - D3 high in power-down; default
// - D5 set on supply failure
// - writing D5 low clears power-fail
// - power failure recalibrates, drops register settings
// - D6 overflow flag, cleared at calibration start
// - D7 high during conversion or calibration
// - register write loads; with D1 and D2 low it starts conversion
// - D3 written high enters power-down
// - register usable while powered down
// - leave power-down by writing D3 low, or by calibrate input low in calibrate mode
// - supply recovery calibrates, stays powered down
// - powered-down write runs one conversion
// - D1 with D3 calibrates in 185 cycles
// - wake-up adds no cycles
// - strobes are NOR of select and strobe
// - hold edge starts conversion within 1.5 cycles
// - latched mode updates outputs at completion
// - hold mode write only latches channel
module afr_func_reg
   import afr_pkg::*;
#(
   parameter int CAL_CYCLES    = `AFR_CAL_CYCLES,
   parameter int SETTLE_CYCLES = `AFR_SETTLE_CYCLES,
   parameter int PD_CAL_TOTAL  = `AFR_PD_CAL_TOTAL
)
(
   input  wire logic       MCLK,          // converter clock, 40 MHz
   input  wire logic       RST_N,         // power-up reset, active low
   input  wire logic       CS_N,          // chip select
   input  wire logic       RD_N,          // read strobe
   input  wire logic       WR_N,          // write strobe
   input  wire logic       FUNCTION_REG_SELECT, // function register select
   input  wire logic       HIGH_BYTE_SELECT,    // high byte select
   input  wire logic       CHANNEL_ADDR_BIT0,   // channel address bit 0
   input  wire logic       CHANNEL_ADDR_BIT1,   // channel address bit 1
   input  wire logic       CAL_HOLD_N,    // calibrate / hold input
   input  wire logic [7:0] DATA_IN,       // data bus input
   input  wire logic       SUPPLY_LOW,    // supply monitor, below threshold
   input  wire logic       CAL_OVERFLOW,  // overflow seen by calibration
   input  wire logic       CONV_DONE_ACK, // unused by logic, either level
   output logic [7:0]      DATA_OUT,      // data bus output
   output logic            DATA_OE_N,     // data bus enable, low drives
   output logic            BUSY_N,        // low during conversion/cal
   output logic            CONV_START,    // one-cycle conversion start
   output logic            CAL_START,     // one-cycle calibration start
   output logic            OUT_LATCH_EN,  // output latches take SAR data
   output logic            CLK_RUN,       // internal clock/analog enable
   output logic            LATCHED_MODE,  // latched output mode
   output logic            HOLD_MODE,     // input is hold control
   output logic [1:0]      CHAN_SEL       // latched channel
);

   // ----------------------------------------------------------------
   // elaboration checks and derived counts
   // ----------------------------------------------------------------
   localparam int CONV_CYCLES = `AFR_CONV_CYCLES;
   localparam int PD_CAL_ONLY = PD_CAL_TOTAL - CONV_CYCLES;

   initial
   begin
      if (CAL_CYCLES < 1 || CAL_CYCLES > 65536)
         $error("afr_func_reg: CAL_CYCLES out of range");
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65536)
         $error("afr_func_reg: SETTLE_CYCLES out of range");
      if (PD_CAL_ONLY < 1)
         $error("afr_func_reg: PD_CAL_TOTAL too small");
      if (`AFR_HOLD_START_CYC < 1)
         $error("afr_func_reg: hold start bound below one cycle");
   end

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_n;

   afr_rst_sync u_rst_sync
   (
      .clk    (MCLK),
      .arst_n (RST_N),
      .rst_n  (rst_n)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   afr_regs_t q;
   afr_regs_t next_q;

   logic       rd_act;
   logic       wr_act;
   logic       wr_end;
   logic       sfr_wr;
   logic       plain_wr;
   logic       cal_rise;
   logic       do_cal;
   logic       do_conv;
   logic       cal_short;
   logic       conv_end;
   logic [7:0] sfr_val;

   // internal strobes are plain NOR terms
   assign rd_act = ~(CS_N | RD_N);
   assign wr_act = ~(CS_N | WR_N);

   assign sfr_val = {q.st != AFR_IDLE,
                     q.calerr,
                     q.pfail,
                     1'b0,
                     q.pdown,
                     q.hold,
                     q.calib,
                     q.latched};

   always_comb
   begin
      next_q = q;

      // ----------------------------------------------------------------
      // strobe capture; a write acts on its rising edge
      // ----------------------------------------------------------------
      next_q.wr_d  = wr_act;
      next_q.cal_d = CAL_HOLD_N;
      next_q.low_d = SUPPLY_LOW;
      if (wr_act)
      begin
         next_q.wdata = DATA_IN;
         next_q.wsel  = {FUNCTION_REG_SELECT, HIGH_BYTE_SELECT, RD_N};
         next_q.wchan = {CHANNEL_ADDR_BIT1, CHANNEL_ADDR_BIT0};
      end
      wr_end   = q.wr_d & ~wr_act;
      sfr_wr   = wr_end & (q.wsel == 3'b111);
      plain_wr = wr_end & ~q.wsel[2] & q.wsel[0];
      cal_rise = ~q.cal_d & CAL_HOLD_N;

      do_cal    = 1'b0;
      do_conv   = 1'b0;
      cal_short = 1'b0;

      // channel latch on any legal write; reserved selects are ignored
      if (plain_wr || sfr_wr)
         next_q.chan = q.wchan;

      // ----------------------------------------------------------------
      // function register write
      // ----------------------------------------------------------------
      // bits 4 and 6 written high are simply dropped
      if (sfr_wr)
      begin
         next_q.latched = q.wdata[`AFR_BIT_LATCHED];
         next_q.hold    = q.wdata[`AFR_BIT_HOLD];
         next_q.pdown   = q.wdata[`AFR_BIT_PDOWN];
         if (!q.wdata[`AFR_BIT_PFAIL])
            next_q.pfail = 1'b0;
         if (q.wdata[`AFR_BIT_CALIB])
         begin
            do_cal    = 1'b1;
            cal_short = q.wdata[`AFR_BIT_PDOWN];
         end
         else if (!q.wdata[`AFR_BIT_HOLD])
            do_conv = 1'b1;
      end

      // a plain write pulse converts unless the hold input owns timing
      if (plain_wr && !q.hold)
         do_conv = 1'b1;

      // ----------------------------------------------------------------
      // calibrate / hold input
      // ----------------------------------------------------------------
      if (!q.hold)
      begin
         if (!CAL_HOLD_N)
            next_q.pdown = 1'b0;
         if (cal_rise)
         begin
            do_cal    = 1'b1;
            cal_short = 1'b0;
         end
      end
      else if (cal_rise)
         do_conv = 1'b1;

      // ----------------------------------------------------------------
      // sequencer
      // ----------------------------------------------------------------
      next_q.conv_start = 1'b0;
      next_q.cal_start  = 1'b0;
      conv_end          = 1'b0;

      case (q.st)
         AFR_IDLE:
         begin
            if (do_cal)
            begin
               next_q.st        = AFR_CAL;
               next_q.cnt       = cal_short ? 16'(PD_CAL_ONLY - 1)
                                            : 16'(CAL_CYCLES - 1);
               next_q.short_cal = cal_short;
               next_q.calib     = 1'b1;
               next_q.calerr    = 1'b0;
               next_q.cal_start = 1'b1;
            end
            else if (do_conv)
            begin
               // started at once: wake-up hides in the sample phase
               next_q.st         = AFR_CONV;
               next_q.cnt        = 16'(CONV_CYCLES - 1);
               next_q.conv_start = 1'b1;
            end
         end
         AFR_SETTLE:
         begin
            next_q.cnt = q.cnt - 16'h0001;
            if (q.cnt == 16'h0000)
            begin
               next_q.st        = AFR_CAL;
               next_q.cnt       = 16'(CAL_CYCLES - 1);
               next_q.short_cal = 1'b0;
               next_q.calerr    = 1'b0;
               next_q.cal_start = 1'b1;
            end
         end
         AFR_CAL:
         begin
            next_q.cnt = q.cnt - 16'h0001;
            if (CAL_OVERFLOW)
               next_q.calerr = 1'b1;
            // convert commands are ignored while calibrating
            if (q.cnt == 16'h0000)
            begin
               next_q.st         = AFR_CONV;
               next_q.cnt        = 16'(CONV_CYCLES - 1);
               next_q.conv_start = 1'b1;
            end
         end
         AFR_CONV:
         begin
            next_q.cnt = q.cnt - 16'h0001;
            if (do_cal)
            begin
               // calibration overrides a running conversion
               next_q.st        = AFR_CAL;
               next_q.cnt       = cal_short ? 16'(PD_CAL_ONLY - 1)
                                            : 16'(CAL_CYCLES - 1);
               next_q.short_cal = cal_short;
               next_q.calib     = 1'b1;
               next_q.calerr    = 1'b0;
               next_q.cal_start = 1'b1;
            end
            else if (q.cnt == 16'h0000)
            begin
               conv_end     = 1'b1;
               next_q.st    = AFR_IDLE;
               next_q.calib = 1'b0;
            end
         end
         default:
         begin
            next_q.st = AFR_IDLE;
         end
      endcase

      // ----------------------------------------------------------------
      // supply failure acts as a reset of the register settings
      // ----------------------------------------------------------------
      if (SUPPLY_LOW)
      begin
         next_q.pfail   = 1'b1;
         next_q.latched = `AFR_RESET_LATCHED;
         next_q.hold    = `AFR_RESET_HOLD;
         next_q.pdown   = `AFR_RESET_PDOWN;
         next_q.calib   = 1'b1;
         next_q.st      = AFR_SETTLE;
         next_q.cnt     = 16'(SETTLE_CYCLES - 1);
         next_q.conv_start = 1'b0;
         next_q.cal_start  = 1'b0;
         conv_end          = 1'b0;
      end

      // ----------------------------------------------------------------
      // registered outputs
      // ----------------------------------------------------------------
      next_q.busy_n  = (next_q.st == AFR_IDLE);
      // a powered-down part runs its clock only while it has work
      next_q.clk_run = ~next_q.pdown
                       | (next_q.st != AFR_IDLE);
      if (next_q.latched)
         next_q.out_latch_en = conv_end;
      else
         next_q.out_latch_en = (next_q.st == AFR_CONV);

      next_q.oe_n = ~(rd_act & WR_N & FUNCTION_REG_SELECT);
      if (HIGH_BYTE_SELECT)
         next_q.dout = sfr_val;
      else
         next_q.dout = `AFR_RESERVED_DATA;
   end

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q              <= '0;
         q.st           <= AFR_SETTLE;
         q.cnt          <= 16'(SETTLE_CYCLES - 1);
         q.latched      <= `AFR_RESET_LATCHED;
         q.hold         <= `AFR_RESET_HOLD;
         q.pdown        <= `AFR_RESET_PDOWN;
         q.calib        <= 1'b1;
         q.cal_d        <= 1'b1;
         q.oe_n         <= 1'b1;
         q.busy_n       <= 1'b0;
         q.clk_run      <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------
   // output wiring
   // ----------------------------------------------------------------
   assign DATA_OUT     = q.dout;
   assign DATA_OE_N    = q.oe_n;
   assign BUSY_N       = q.busy_n;
   assign CONV_START   = q.conv_start;
   assign CAL_START    = q.cal_start;
   assign OUT_LATCH_EN = q.out_latch_en;
   assign CLK_RUN      = q.clk_run;
   assign LATCHED_MODE = q.latched;
   assign HOLD_MODE    = q.hold;
   assign CHAN_SEL     = q.chan;

endmodule // afr_func_reg

// ===== afr_func_reg_chk.sv
`timescale 1ns/1ps
module afr_func_reg_chk
(
   input wire logic       MCLK,                // converter clock
   input wire logic       RST_N,               // reset, active low
   input wire logic       CS_N,                // chip select
   input wire logic       RD_N,                // read strobe
   input wire logic       WR_N,                // write strobe
   input wire logic       FUNCTION_REG_SELECT, // register select
   input wire logic       HIGH_BYTE_SELECT,    // high byte select
   input wire logic       CAL_HOLD_N,          // calibrate / hold
   input wire logic [7:0] DATA_IN,             // write data
   input wire logic [7:0] DATA_OUT,            // read data
   input wire logic       DATA_OE_N,           // bus enable
   input wire logic       BUSY_N,              // busy, active low
   input wire logic       CONV_START,          // conversion start
   input wire logic       OUT_LATCH_EN,        // output latch enable
   input wire logic       CLK_RUN,             // clock enable
   input wire logic       LATCHED_MODE,        // latched mode
   input wire logic       HOLD_MODE            // hold mode
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   property p_oe_read;
      !CS_N && !RD_N && WR_N && FUNCTION_REG_SELECT |=> !DATA_OE_N;
   endproperty
   a_oe_read: assert property (p_oe_read)
      else $error("bus not driven on register read");
   property p_release;
      !(!CS_N && !RD_N && WR_N && FUNCTION_REG_SELECT) |=> DATA_OE_N;
   endproperty
   a_release: assert property (p_release)
      else $error("bus driven outside a read");
   property p_mode_bits;
      !DATA_OE_N && $past(HIGH_BYTE_SELECT) |-> DATA_OUT[0] == LATCHED_MODE
         && DATA_OUT[2] == HOLD_MODE && !DATA_OUT[4];
   endproperty
   a_mode_bits: assert property (p_mode_bits)
      else $error("mode bits differ from mode outputs");
   property p_busy_conv;
      CONV_START |-> !BUSY_N ##1 (!BUSY_N)[*8];
   endproperty
   a_busy_conv: assert property (p_busy_conv)
      else $error("busy not low during conversion");
   property p_hold_start;
      HOLD_MODE && BUSY_N && $rose(CAL_HOLD_N) |=> CONV_START;
   endproperty
   a_hold_start: assert property (p_hold_start)
      else $error("hold edge did not start conversion");
   property p_hold_wr;
      HOLD_MODE && $past(!CS_N && !WR_N) && (CS_N || WR_N)
         && !$past(FUNCTION_REG_SELECT) |-> (!CONV_START)[*3];
   endproperty
   a_hold_wr: assert property (p_hold_wr)
      else $error("write started conversion in hold mode");
   property p_wr_conv;
      !HOLD_MODE && BUSY_N && $past(!CS_N && !WR_N) && (CS_N || WR_N)
         && $past(FUNCTION_REG_SELECT && HIGH_BYTE_SELECT)
         && $past(DATA_IN[2:1]) == 2'b00 |-> ##[1:3] CONV_START;
   endproperty
   a_wr_conv: assert property (p_wr_conv)
      else $error("register write did not start conversion");
   property p_latch_pulse;
      LATCHED_MODE && OUT_LATCH_EN |=> !OUT_LATCH_EN;
   endproperty
   a_latch_pulse: assert property (p_latch_pulse)
      else $error("latched mode update longer than one cycle");
   property p_clk_stop;
      !CLK_RUN |-> BUSY_N && !CONV_START;
   endproperty
   a_clk_stop: assert property (p_clk_stop)
      else $error("clock stopped while busy");
endmodule // afr_func_reg_chk

bind afr_func_reg afr_func_reg_chk u_chk
(
   .MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
   .FUNCTION_REG_SELECT(FUNCTION_REG_SELECT),
   .HIGH_BYTE_SELECT(HIGH_BYTE_SELECT), .CAL_HOLD_N(CAL_HOLD_N),
   .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
   .BUSY_N(BUSY_N), .CONV_START(CONV_START), .OUT_LATCH_EN(OUT_LATCH_EN),
   .CLK_RUN(CLK_RUN), .LATCHED_MODE(LATCHED_MODE), .HOLD_MODE(HOLD_MODE)
);

// ===== afr_host.sv
`timescale 1ns/1ps
module afr_host
(
   input  wire logic       clk,   // converter clock
   input  wire logic [7:0] dout,  // bus data from device
   output logic            cs_n,  // chip select
   output logic            rd_n,  // read strobe
   output logic            wr_n,  // write strobe
   output logic            fsel,  // register select
   output logic            hsel,  // high byte select
   output logic [1:0]      addr,  // channel address
   output logic            cal_n, // calibrate / hold
   output logic [7:0]      din    // bus data to device
);
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      fsel = 1'b1;
      hsel = 1'b1;
      addr = 2'b00;
      cal_n = 1'b1;
      din = 8'h5A;
   end

   task automatic wr(input logic f, input logic h, input logic [1:0] a,
                     input logic [7:0] d);
      @(negedge clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      fsel = f;
      hsel = h;
      addr = a;
      din = d & 8'h8F;
      repeat (4) @(negedge clk);
      wr_n = 1'b1;
      cs_n = 1'b1;
      @(negedge clk);
      // released bus never keeps the last value
      din = ~din;
   endtask

   task automatic rd(input logic f, input logic h,
                     output logic [7:0] q);
      @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      fsel = f;
      hsel = h;
      repeat (2) @(negedge clk);
      q = dout;
      rd_n = 1'b1;
      cs_n = 1'b1;
   endtask

   task automatic pulse(input int lo);
      @(negedge clk);
      cal_n = 1'b0;
      repeat (lo) @(negedge clk);
      cal_n = 1'b1;
   endtask
endmodule // afr_host

// ===== afr_func_reg_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   n_mismatch++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module afr_func_reg_tb;
   logic       MCLK, RST_N, SUPPLY_LOW, CAL_OVERFLOW, CONV_DONE_ACK;
   logic       CS_N, RD_N, WR_N, FSEL, HSEL, CAL_HOLD_N;
   logic [1:0] ADDR, CHAN_SEL;
   logic [7:0] DATA_IN, DATA_OUT, q;
   logic       DATA_OE_N, BUSY_N, CONV_START, CAL_START, OUT_LATCH_EN;
   logic       CLK_RUN, LATCHED_MODE, HOLD_MODE;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   int         n;

   afr_func_reg #(.CAL_CYCLES(20), .SETTLE_CYCLES(10), .PD_CAL_TOTAL(185))
   uut (.MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
      .FUNCTION_REG_SELECT(FSEL), .HIGH_BYTE_SELECT(HSEL),
      .CHANNEL_ADDR_BIT0(ADDR[0]), .CHANNEL_ADDR_BIT1(ADDR[1]),
      .CAL_HOLD_N(CAL_HOLD_N), .DATA_IN(DATA_IN), .SUPPLY_LOW(SUPPLY_LOW),
      .CAL_OVERFLOW(CAL_OVERFLOW), .CONV_DONE_ACK(CONV_DONE_ACK),
      .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .BUSY_N(BUSY_N),
      .CONV_START(CONV_START), .CAL_START(CAL_START),
      .OUT_LATCH_EN(OUT_LATCH_EN), .CLK_RUN(CLK_RUN),
      .LATCHED_MODE(LATCHED_MODE), .HOLD_MODE(HOLD_MODE),
      .CHAN_SEL(CHAN_SEL));

   afr_host host (.clk(MCLK), .dout(DATA_OUT), .cs_n(CS_N), .rd_n(RD_N),
      .wr_n(WR_N), .fsel(FSEL), .hsel(HSEL), .addr(ADDR),
      .cal_n(CAL_HOLD_N), .din(DATA_IN));

   initial
   begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end

   task automatic final_report;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_idle(output int c);
      c = 0;
      repeat (3) @(negedge MCLK);
      while (BUSY_N !== 1'b1 && c < 3000)
      begin
         @(negedge MCLK);
         c++;
      end
      `CHK("idle", 1'b1, BUSY_N)
   endtask

   task automatic rchk(input logic h, input logic [7:0] e);
      host.rd(1'b1, h, q);
      `CHK("freg", e, q)
   endtask

   // ---------------------------------------------------------------
   // watchdog: whole sequence needs well under 3000 cycles
   // ---------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge MCLK);
      n_mismatch++;
      final_report;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      RST_N = 1'b0;
      SUPPLY_LOW = 1'b0;
      CAL_OVERFLOW = 1'b0;
      CONV_DONE_ACK = 1'b0;
      repeat (5) @(negedge MCLK);
      RST_N = 1'b1;
      wait_idle(n);
      rchk(1'b1, 8'h08);
      // a conversion-data read is not ours to answer
      host.rd(1'b0, 1'b0, q);
      `CHK("oe_data", 1'b1, DATA_OE_N)
      host.wr(1'b1, 1'b1, 2'b00, 8'h01);
      rchk(1'b1, 8'h81);
      wait_idle(n);
      `CHK("latched", 1'b1, LATCHED_MODE)
      host.wr(1'b1, 1'b1, 2'b00, 8'h08);
      wait_idle(n);
      repeat (2) @(negedge MCLK);
      `CHK("clk_run", 1'b0, CLK_RUN)
      rchk(1'b1, 8'h08);
      host.wr(1'b1, 1'b1, 2'b00, 8'h0A);
      wait_idle(n);
      // busy fell one edge before wr returned; wait_idle skips three
      `CHK("pd_cal_len", 185, n + 3)
      rchk(1'b1, 8'h08);
      CAL_OVERFLOW = 1'b1;
      host.wr(1'b1, 1'b1, 2'b00, 8'h02);
      // overflow is flagged from the first calibration cycle
      rchk(1'b1, 8'hC2);
      wait_idle(n);
      CAL_OVERFLOW = 1'b0;
      rchk(1'b1, 8'h40);
      host.wr(1'b1, 1'b1, 2'b00, 8'h0A);
      rchk(1'b1, 8'h8A);
      wait_idle(n);
      rchk(1'b1, 8'h08);
      host.pulse(4);
      rchk(1'b1, 8'h82);
      wait_idle(n);
      // latched plus hold mode, cleared again by the supply failure
      host.wr(1'b1, 1'b1, 2'b00, 8'h05);
      wait_idle(n);
      host.wr(1'b0, 1'b0, 2'b10, 8'h00);
      `CHK("chan", 2'b10, CHAN_SEL)
      `CHK("no_conv", 1'b1, BUSY_N)
      host.pulse(100);
      repeat (2) @(negedge MCLK);
      `CHK("hold_conv", 1'b0, BUSY_N)
      wait_idle(n);
      SUPPLY_LOW = 1'b1;
      repeat (3) @(negedge MCLK);
      SUPPLY_LOW = 1'b0;
      wait_idle(n);
      rchk(1'b1, 8'h28);
      `CHK("latched", 1'b0, LATCHED_MODE)
      `CHK("hold", 1'b0, HOLD_MODE)
      // the acknowledge input is ignored by the block
      CONV_DONE_ACK = 1'b1;
      host.wr(1'b1, 1'b1, 2'b00, 8'h08);
      wait_idle(n);
      rchk(1'b1, 8'h08);
      repeat (2) @(negedge MCLK);
      `CHK("clk_run", 1'b0, CLK_RUN)
      final_report;
   end
endmodule // afr_func_reg_tb
